// file: thermal_pkg.sv
package thermal_pkg;
   localparam int addr_w = 8;
   localparam int temp_w = 8;
   // register byte offsets
   localparam logic [7:0] off_catastrophic_trip_ctrl = 8'h00;
   localparam logic [7:0] off_catastrophic_trip_setting = 8'h04;
   localparam logic [7:0] off_sensor_config_ctrl = 8'h08;
   localparam logic [7:0] off_hw_throttle_ctrl = 8'h0c;
   localparam logic [7:0] off_write_throttle_cfg = 8'h10;
   localparam logic [7:0] off_int_status = 8'h14;
   localparam logic [7:0] off_int_mask = 8'h18;
   localparam logic [7:0] off_temperature = 8'h1c;
   localparam logic [7:0] off_trip_state = 8'h20;
   // field positions
   localparam int catastrophic_lock_bit = 31;
   localparam int catastrophic_shutdown_en_bit = 0;
   localparam int sensor_enable_bit = 0;
   localparam int trip_adjust_bit = 1;
   localparam int hw_throttle_lock_bit = 31;
   localparam int hw_throttle_both_bit = 0;
   localparam int hw_throttle_en_bit = 1;
   localparam int ext_int_en_bit = 2;
   localparam int ext_read_throttle_en_bit = 3;
   localparam int high_int_en_bit = 4;
   // status bits
   localparam int st_high_rise = 0;
   localparam int st_high_fall = 1;
   localparam int st_catastrophic = 2;
   localparam int st_ext_overtemp = 3;
   localparam int status_w = 4;
   // values after reset and fixed distances
   localparam logic [7:0] reset_trip_setting = 8'h69;
   localparam logic [7:0] high_trip_offset = 8'h0e;
   localparam logic [7:0] hysteresis_default = 8'h02;
   typedef enum logic [1:0] {
      temp_normal = 2'b00,
      temp_high = 2'b01,
      temp_catastrophic = 2'b10
   } temp_zone_t;
endpackage

// file: thermal_trip_throttle_control.sv
// The AHB-Lite register port and the address map were decided locally.
`timescale 1ns/10ps
// Overview of operation
// - catastrophic trip setting held; reaching it asserts shutdown at once
// - high trip sits fourteen degrees below the catastrophic trip
// - enabled interrupt on each high trip crossing, rising or falling
// - hardware starts throttling on hot trip without software
// - throttle control picks catastrophic only or both trips for write throttle
// - write throttle config is a master gate for all write throttling
// - catastrophic lock freezes catastrophic ctrl, setting, two sensor config bits
// - throttle control lock freezes hardware throttle settings
// - trip comparisons use hysteresis so levels do not chatter
// - active-low level input raises interrupt and/or read throttle
// - no hysteresis on external input; level acted on directly
// - wired-or sensors; read throttle applies to all modules alike
module thermal_trip_throttle_control #(
   parameter int hysteresis = 2
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // sensor and pins
   input wire logic [thermal_pkg::temp_w-1:0] sensor_temp,
   input wire logic ext_overtemp_n,
   // actions
   output logic shutdown,
   output logic write_throttle,
   output logic read_throttle,
   output logic irq
);
   import thermal_pkg::*;

   // catastrophic interface, frozen by its lock
   logic catastrophic_lock;
   logic catastrophic_shutdown_en;
   logic [7:0] catastrophic_trip_setting;
   logic sensor_enable;
   logic trip_adjust;

   // hardware throttle settings, frozen by their own lock
   logic hw_throttle_lock;
   logic hw_throttle_both;
   logic hw_throttle_en;
   logic ext_int_en;
   logic ext_read_throttle_en;
   logic high_int_en;

   // gate, status and mask
   logic write_throttle_cfg;
   logic [status_w-1:0] int_status;
   logic [status_w-1:0] int_mask;
   logic [status_w-1:0] events;

   // trip state and bus bookkeeping
   logic high_hot;
   logic cat_hot;
   logic ext_hot_q;
   logic wr_pend;
   logic [7:0] wr_addr;
   logic [7:0] cat_point;
   logic [7:0] high_point;
   logic [7:0] hyst;
   logic next_high_hot;
   logic next_cat_hot;
   logic [31:0] next_hrdata;

   assign hyst = 8'(hysteresis);

   // trip adjust moves the catastrophic point up by the hysteresis band
   assign cat_point = trip_adjust ? sat_add(catastrophic_trip_setting, hyst) : catastrophic_trip_setting;
   assign high_point = cat_point - high_trip_offset;

   // saturate so a raised point near full scale never wraps to a cold value
   function automatic logic [7:0] sat_add(input logic [7:0] a, input logic [7:0] b);
      logic [8:0] s;
      s = {1'b0, a} + {1'b0, b};
      return s[8] ? 8'hff : s[7:0];
   endfunction

   // one extra bit so a reading near full scale cannot wrap below the point
   function automatic logic hyst_cmp(input logic hot, input logic [7:0] t, input logic [7:0] p,
                                     input logic [7:0] h);
      logic [8:0] sum;
      sum = {1'b0, t} + {1'b0, h};
      if (hot)
         return sum >= {1'b0, p};
      else
         return t >= p;
   endfunction

   // an address phase is ours only while the bus is ready and selected
   function automatic logic bus_take(input logic rdy, input logic sel, input logic [1:0] trans);
      return rdy && sel && trans[1];
   endfunction

   always_comb begin
      next_high_hot = sensor_enable && hyst_cmp(high_hot, sensor_temp, high_point, hyst);
      next_cat_hot = sensor_enable && hyst_cmp(cat_hot, sensor_temp, cat_point, hyst);
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         high_hot <= 1'b0;
         cat_hot <= 1'b0;
         ext_hot_q <= 1'b0;
      end else begin
         high_hot <= next_high_hot;
         cat_hot <= next_cat_hot;
         ext_hot_q <= !ext_overtemp_n;
      end
   end

   // edge events; the external overtemp event follows its level
   always_comb begin
      events = '0;
      events[st_high_rise] = high_int_en && next_high_hot && !high_hot;
      events[st_high_fall] = high_int_en && !next_high_hot && high_hot;
      events[st_catastrophic] = next_cat_hot && !cat_hot;
      events[st_ext_overtemp] = ext_int_en && ext_hot_q;
   end

   // ahb address phase capture
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
      end else if (hready) begin
         wr_pend <= bus_take(hready, hsel, htrans) && hwrite;
         wr_addr <= haddr[7:0];
      end
   end

   // catastrophic interface, locked once set
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         catastrophic_lock <= 1'b0;
         catastrophic_shutdown_en <= 1'b0;
         catastrophic_trip_setting <= reset_trip_setting;
         sensor_enable <= 1'b0;
         trip_adjust <= 1'b0;
      end else if (wr_pend && !catastrophic_lock) begin
         if (wr_addr == off_catastrophic_trip_ctrl) begin
            catastrophic_lock <= hwdata[catastrophic_lock_bit];
            catastrophic_shutdown_en <= hwdata[catastrophic_shutdown_en_bit];
         end else if (wr_addr == off_catastrophic_trip_setting) begin
            catastrophic_trip_setting <= hwdata[7:0];
         end else if (wr_addr == off_sensor_config_ctrl) begin
            sensor_enable <= hwdata[sensor_enable_bit];
            trip_adjust <= hwdata[trip_adjust_bit];
         end
      end
   end

   // hardware throttle settings, own lock
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hw_throttle_lock <= 1'b0;
         hw_throttle_both <= 1'b0;
         hw_throttle_en <= 1'b0;
         ext_int_en <= 1'b0;
         ext_read_throttle_en <= 1'b0;
         high_int_en <= 1'b0;
      end else if (wr_pend && wr_addr == off_hw_throttle_ctrl && !hw_throttle_lock) begin
         hw_throttle_lock <= hwdata[hw_throttle_lock_bit];
         hw_throttle_both <= hwdata[hw_throttle_both_bit];
         hw_throttle_en <= hwdata[hw_throttle_en_bit];
         ext_int_en <= hwdata[ext_int_en_bit];
         ext_read_throttle_en <= hwdata[ext_read_throttle_en_bit];
         high_int_en <= hwdata[high_int_en_bit];
      end
   end

   // master gate and mask
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         write_throttle_cfg <= 1'b0;
         int_mask <= '0;
      end else if (wr_pend) begin
         if (wr_addr == off_write_throttle_cfg) begin
            write_throttle_cfg <= hwdata[0];
         end else if (wr_addr == off_int_mask) begin
            int_mask <= hwdata[status_w-1:0];
         end
      end
   end

   // sticky status, set wins over write-one-clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         int_status <= '0;
      end else if (wr_pend && wr_addr == off_int_status) begin
         int_status <= (int_status & ~hwdata[status_w-1:0]) | events;
      end else begin
         int_status <= int_status | events;
      end
   end

   // shutdown from the next trip state, so it lands with the trip itself
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         shutdown <= 1'b0;
      end else begin
         shutdown <= catastrophic_shutdown_en && next_cat_hot;
      end
   end

   // write throttle needs the master gate as well as the hardware enable
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         write_throttle <= 1'b0;
      end else begin
         write_throttle <= write_throttle_cfg && hw_throttle_en &&
                           (next_cat_hot || (hw_throttle_both && next_high_hot));
      end
   end

   // read throttle follows the pin level unfiltered; one gate for all modules
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         read_throttle <= 1'b0;
      end else begin
         read_throttle <= ext_read_throttle_en && ext_hot_q;
      end
   end

   // includes this cycle's events so a fresh cause is not missed
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |((int_status | events) & int_mask);
      end
   end

   // read data mux; unmapped offsets read as zero
   always_comb begin
      next_hrdata = 32'h00000000;
      if (haddr[7:0] == off_catastrophic_trip_ctrl) begin
         next_hrdata = {catastrophic_lock, 30'h00000000, catastrophic_shutdown_en};
      end else if (haddr[7:0] == off_catastrophic_trip_setting) begin
         next_hrdata = {24'h000000, catastrophic_trip_setting};
      end else if (haddr[7:0] == off_sensor_config_ctrl) begin
         next_hrdata = {30'h00000000, trip_adjust, sensor_enable};
      end else if (haddr[7:0] == off_hw_throttle_ctrl) begin
         next_hrdata = {hw_throttle_lock, 26'h0000000, high_int_en, ext_read_throttle_en, ext_int_en,
                        hw_throttle_en, hw_throttle_both};
      end else if (haddr[7:0] == off_write_throttle_cfg) begin
         next_hrdata = {31'h00000000, write_throttle_cfg};
      end else if (haddr[7:0] == off_int_status) begin
         next_hrdata = {28'h0000000, int_status};
      end else if (haddr[7:0] == off_int_mask) begin
         next_hrdata = {28'h0000000, int_mask};
      end else if (haddr[7:0] == off_temperature) begin
         next_hrdata = {24'h000000, sensor_temp};
      end else if (haddr[7:0] == off_trip_state) begin
         next_hrdata = {29'h00000000, ext_hot_q, cat_hot, high_hot};
      end
   end

   // registered at the address phase, so the data phase needs no wait state
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h00000000;
      end else if (bus_take(hready, hsel, htrans) && !hwrite) begin
         hrdata <= next_hrdata;
      end
   end

   // no wait states are ever inserted
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
      end else begin
         hreadyout <= 1'b1;
      end
   end

   // refused writes are dropped silently, so the response is always okay
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hresp <= 1'b0;
      end else begin
         hresp <= 1'b0;
      end
   end
endmodule // thermal_trip_throttle_control

// file: thermal_trip_throttle_control_properties.sv
`timescale 1ns/10ps
module thermal_trip_throttle_control_properties import thermal_pkg::*; (
   // bus
   input wire logic hclk, input wire logic hresetn, input wire logic hsel, input wire logic [31:0] haddr,
   input wire logic [1:0] htrans, input wire logic hwrite, input wire logic hready,
   input wire logic [31:0] hrdata, input wire logic hreadyout, input wire logic hresp,
   // thermal
   input wire logic [temp_w-1:0] sensor_temp, input wire logic ext_overtemp_n, input wire logic shutdown,
   input wire logic write_throttle, input wire logic read_throttle, input wire logic irq
);
   logic rd_dp, wr_dp;
   logic [7:0] rd_a;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rd_dp <= 1'b0;
         wr_dp <= 1'b0;
         rd_a <= 8'h00;
      end else begin
         rd_dp <= hsel && hready && htrans[1] && !hwrite;
         wr_dp <= hsel && hready && htrans[1] && hwrite;
         rd_a <= haddr[7:0];
      end
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence s_ext_high;
      ext_overtemp_n [*2];
   endsequence
   sequence s_cold;
      (sensor_temp == 8'h00) [*2];
   endsequence
   a_bus_okay: assert property (hreadyout && !hresp) else $error("bus response not okay");
   a_unmapped_zero: assert property (rd_dp && rd_a > off_trip_state |-> hrdata == 32'h0)
      else $error("unmapped read not zero");
   a_temp_readback: assert property (rd_dp && rd_a == off_temperature && $stable(sensor_temp) &&
      $past(sensor_temp) == $past(sensor_temp, 2) |-> hrdata[7:0] == sensor_temp) else $error("temperature readback");
   a_ext_cause: assert property ($rose(read_throttle) |-> $past(ext_overtemp_n, 2) == 1'b0)
      else $error("read throttle without low input");
   a_ext_release: assert property (s_ext_high |=> !read_throttle)
      else $error("read throttle held after release");
   a_irq_clear: assert property ($fell(irq) |-> $past(wr_dp) || $past(wr_dp, 2))
      else $error("interrupt dropped without write");
   a_shutdown_cause: assert property ($rose(shutdown) |-> $past(wr_dp) || $past(wr_dp, 2) ||
      $past(sensor_temp) > $past(sensor_temp, 2) || $past(sensor_temp, 2) > $past(sensor_temp, 3))
      else $error("shutdown without rising temperature");
   a_throttle_fall: assert property ($fell(write_throttle) |-> $past(wr_dp) || $past(wr_dp, 2) ||
      $past(sensor_temp) < $past(sensor_temp, 2) || $past(sensor_temp, 2) < $past(sensor_temp, 3))
      else $error("throttle dropped without cooling");
   a_cold_quiet: assert property (s_cold |=> !shutdown && !write_throttle)
      else $error("trip active while cold");
endmodule // thermal_trip_throttle_control_properties

// file: ext_sensor_model.sv
`timescale 1ns/10ps
// two board sensors sharing one open-drain line with a pull-up
module ext_sensor_model #(
   parameter logic [7:0] trip = 8'h50,
   parameter logic [7:0] hyst = 8'h03
) (
   input wire logic hclk,
   input wire logic [7:0] temp_a,
   input wire logic [7:0] temp_b,
   output logic ext_overtemp_n
);
   logic hot_a = 1'b0;
   logic hot_b = 1'b0;
   // own hysteresis, the receiver has none
   always_ff @(posedge hclk) begin
      hot_a <= (temp_a >= trip) ? 1'b1 : (temp_a < trip - hyst) ? 1'b0 : hot_a;
      hot_b <= (temp_b >= trip) ? 1'b1 : (temp_b < trip - hyst) ? 1'b0 : hot_b;
   end
   // released line floats up through the pull-up
   assign ext_overtemp_n = !(hot_a || hot_b);
endmodule // ext_sensor_model

// file: thermal_trip_throttle_control_bench.sv
`timescale 1ns/10ps
module thermal_trip_throttle_control_bench;
   import thermal_pkg::*;
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, shutdown, write_throttle, read_throttle, irq;
   logic ext_overtemp_n;
   logic [1:0] htrans;
   logic [31:0] haddr, hwdata, hrdata;
   logic [7:0] sensor_temp, temp_a, temp_b;
   int errors = 0;
   int n_checks = 0;
   localparam logic [7:0] hp = reset_trip_setting - high_trip_offset;
   assign hready = hreadyout;
   thermal_trip_throttle_control dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .sensor_temp(sensor_temp), .ext_overtemp_n(ext_overtemp_n),
      .shutdown(shutdown), .write_throttle(write_throttle), .read_throttle(read_throttle), .irq(irq));
   ext_sensor_model sens_u (.hclk(hclk), .temp_a(temp_a), .temp_b(temp_b), .ext_overtemp_n(ext_overtemp_n));
   initial begin
      hclk = 1'b0;
      forever #50 hclk = ~hclk;
   end
   task end_of_test;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         errors++;
         $display("MISMATCH %s exp %h got %h", nm, e, g);
      end
   endtask
   // bounded wait for the slave's ready
   task wt;
      int i;
      i = 0;
      do begin
         @(posedge hclk);
         i++;
      end while (hreadyout !== 1'b1 && i < 16);
      if (hreadyout !== 1'b1) begin
         errors++;
         end_of_test;
      end
   endtask
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {24'h0, a};
      wt;
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      wt;
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      chk($sformatf("reg %h", a), e, hrdata);
   endtask
   // order: shutdown, write throttle, read throttle, irq
   task pins(input logic [3:0] e);
      @(posedge hclk);
      #1;
      chk("pins", {28'h0, e}, {28'h0, shutdown, write_throttle, read_throttle, irq});
      @(posedge hclk);
   endtask
   task th(input logic [7:0] t, input logic [7:0] a, input logic [7:0] b);
      sensor_temp <= t;
      temp_a <= a;
      temp_b <= b;
      repeat (4) @(posedge hclk);
   endtask
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      htrans = 2'b00;
      hwrite = 1'b0;
      haddr = 32'h0;
      hwdata = 32'h0;
      sensor_temp = 8'h00;
      temp_a = 8'h00;
      temp_b = 8'h00;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd(off_catastrophic_trip_setting, {24'h0, reset_trip_setting});
      rd(off_catastrophic_trip_ctrl, 32'h0);
      xfer(1'b1, 8'h40, 32'hffffffff);
      rd(8'h40, 32'h0);
      xfer(1'b1, off_sensor_config_ctrl, 32'h1);
      xfer(1'b1, off_int_mask, 32'hf);
      xfer(1'b1, off_catastrophic_trip_ctrl, 32'h1);
      xfer(1'b1, off_hw_throttle_ctrl, 32'h12);
      xfer(1'b1, off_write_throttle_cfg, 32'h1);
      th(hp - 8'h01, 8'h00, 8'h00);
      rd(off_trip_state, 32'h0);
      th(hp, 8'h00, 8'h00);
      rd(off_trip_state, 32'h1);
      pins(4'b0001);
      th(hp - 8'h01, 8'h00, 8'h00);
      rd(off_trip_state, 32'h1);
      th(reset_trip_setting, 8'h00, 8'h00);
      pins(4'b1101);
      xfer(1'b1, off_write_throttle_cfg, 32'h0);
      pins(4'b1001);
      th(hp - 8'h03, 8'h00, 8'h00);
      rd(off_int_status, 32'h7);
      xfer(1'b1, off_int_status, 32'h7);
      pins(4'b0000);
      xfer(1'b1, off_hw_throttle_ctrl, 32'h13);
      xfer(1'b1, off_write_throttle_cfg, 32'h1);
      th(hp, 8'h00, 8'h00);
      pins(4'b0101);
      th(hp - 8'h03, 8'h00, 8'h00);
      xfer(1'b1, off_int_status, 32'h7);
      xfer(1'b1, off_catastrophic_trip_ctrl, 32'h80000001);
      xfer(1'b1, off_catastrophic_trip_setting, 32'h50);
      rd(off_catastrophic_trip_setting, {24'h0, reset_trip_setting});
      xfer(1'b1, off_sensor_config_ctrl, 32'h0);
      rd(off_sensor_config_ctrl, 32'h1);
      xfer(1'b1, off_catastrophic_trip_ctrl, 32'h0);
      rd(off_catastrophic_trip_ctrl, 32'h80000001);
      xfer(1'b1, off_hw_throttle_ctrl, 32'h8000001f);
      xfer(1'b1, off_hw_throttle_ctrl, 32'h0);
      rd(off_hw_throttle_ctrl, 32'h8000001f);
      th(8'h20, 8'h60, 8'h00);
      pins(4'b0011);
      rd(off_int_status, 32'h8);
      th(8'h20, 8'h40, 8'h60);
      pins(4'b0011);
      th(8'h20, 8'h40, 8'h40);
      pins(4'b0001);
      xfer(1'b1, off_int_mask, 32'h0);
      pins(4'b0000);
      rd(off_temperature, 32'h20);
      end_of_test;
   end
endmodule // thermal_trip_throttle_control_bench
bind thermal_trip_throttle_control thermal_trip_throttle_control_properties props_u (.hclk(hclk),
   .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
   .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sensor_temp(sensor_temp),
   .ext_overtemp_n(ext_overtemp_n), .shutdown(shutdown), .write_throttle(write_throttle),
   .read_throttle(read_throttle), .irq(irq));
